// ===== hw/acps_params.svh
// Constants for the conversion and power sequencer.
// Assumes inclusion by the package and the top module only.
`ifndef ACPS_PARAMS_SVH
`define ACPS_PARAMS_SVH
`define ACPS_LEAD_ZEROS     4
`define ACPS_HOLD_EDGE      5'h03
`define ACPS_EDGES_12BIT    5'h10
`define ACPS_EDGES_10BIT    5'h0E
`define ACPS_EDGES_8BIT     5'h0C
`define ACPS_FIFO_WIDTH     12
`define ACPS_FIFO_DEPTH     32
`endif

// ===== hw/acps_pkg.sv
// Types for the conversion and power sequencer.
// Assumes acps_params.svh sits on the include path.
`include "acps_params.svh"
package acps_pkg;
   typedef enum logic [1:0] {
      ACPS_RES_12 = 2'h0,
      ACPS_RES_10 = 2'h1,
      ACPS_RES_8  = 2'h2
   } acps_res_e;
   typedef enum logic [1:0] {
      ACPS_POWER_DOWN = 2'h0,
      ACPS_TRACK      = 2'h1,
      ACPS_CONVERT    = 2'h3
   } acps_state_e;
   typedef struct packed {
      logic [`ACPS_FIFO_WIDTH-1:0] code;
   } acps_sample_s;
   typedef struct packed {
      logic track;
      logic powered;
      logic busy;
   } acps_status_s;
endpackage

// ===== hw/acps_fifo.sv
// Sample FIFO in front of the serial shifter.
// Assumes one clock domain; width and depth set by parameters.
module acps_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 32,
   parameter int AW    = $clog2(DEPTH)
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             reset,
   input  wire logic             clk_en,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ff, rd_ff, nxt_wr, nxt_rd;
   logic             push, pop;

   always_comb begin
      in_ready  = (wr_ff - rd_ff) != (AW+1)'(DEPTH);
      out_valid = wr_ff != rd_ff;
      out_data  = mem[rd_ff[AW-1:0]];
      push      = clk_en && in_valid && in_ready;
      pop       = clk_en && out_valid && out_ready;
      nxt_wr    = push ? wr_ff + 1'b1 : wr_ff;
      nxt_rd    = pop ? rd_ff + 1'b1 : rd_ff;
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         wr_ff <= '0;
         rd_ff <= '0;
      end else begin
         wr_ff <= nxt_wr;
         rd_ff <= nxt_rd;
      end
   end

   // Storage has no reset, so no async path touches data
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wr_ff[AW-1:0]] <= in_data;
      end
   end
endmodule

// ===== hw/acps_top.sv
// Conversion and power sequencer of a serial SAR converter.
// Assumes select and serial clock come from a host, off domain.
module acps_top
   import acps_pkg::*;
(
   // Clock, reset, enable
   input  wire logic                  core_clk,
   input  wire logic                  reset,
   input  wire logic                  clk_en,
   // Variant strap, static
   input  wire logic [1:0]            res_sel,
   // Converter results from the analog core
   input  wire logic                  sample_valid,
   output logic                       sample_ready,
   input  wire acps_sample_s          sample_in,
   // Host serial pins
   input  wire logic                  conv_sel_n,
   input  wire logic                  serial_clk,
   output logic                       serial_result_out,
   output logic                       serial_result_oe,
   // Analog control
   output acps_status_s               status
);
   // Two-flop pin synchronisers, then one history flop for edges
   logic [1:0] cs_sync_ff, ck_sync_ff;
   logic       cs_prev_ff, ck_prev_ff;
   logic       cs_fall, cs_rise, ck_fall;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cs_sync_ff <= 2'h3;
         ck_sync_ff <= 2'h3;
         cs_prev_ff <= 1'b1;
         ck_prev_ff <= 1'b1;
      end else if (clk_en) begin
         cs_sync_ff <= {cs_sync_ff[0], conv_sel_n};
         ck_sync_ff <= {ck_sync_ff[0], serial_clk};
         cs_prev_ff <= cs_sync_ff[1];
         ck_prev_ff <= ck_sync_ff[1];
      end
   end

   always_comb begin
      cs_fall = cs_prev_ff && !cs_sync_ff[1];
      cs_rise = !cs_prev_ff && cs_sync_ff[1];
      ck_fall = ck_prev_ff && !ck_sync_ff[1] && !cs_sync_ff[1];
   end

   function automatic logic [4:0] last_edge(input logic [1:0] r);
      case (r)
         ACPS_RES_10: last_edge = `ACPS_EDGES_10BIT;
         ACPS_RES_8:  last_edge = `ACPS_EDGES_8BIT;
         default:     last_edge = `ACPS_EDGES_12BIT;
      endcase
   endfunction

   function automatic logic [15:0] frame_word(input logic [1:0] r,
                                              input logic [11:0] c);
      case (r)
         ACPS_RES_10: frame_word = {4'h0, c[9:0], 2'h0};
         ACPS_RES_8:  frame_word = {4'h0, c[7:0], 4'h0};
         default:     frame_word = {4'h0, c};
      endcase
   endfunction

   // Strap caught once after reset release, never under async reset
   logic [1:0] res_ff, nxt_res;
   logic       strap_ok_ff;

   acps_sample_s    fifo_data;
   logic            fifo_valid;
   logic            fifo_pop;

   // Ready registered from the next fill level, so it never lags a pop
   logic [5:0] fill_ff, nxt_fill;
   logic       ready_ff, nxt_ready;
   logic       fifo_push;

   always_comb begin
      fifo_push = sample_valid && ready_ff;
      nxt_fill  = fill_ff;
      if (fifo_push && !fifo_pop) begin
         nxt_fill = fill_ff + 6'h01;
      end else if (!fifo_push && fifo_pop) begin
         nxt_fill = fill_ff - 6'h01;
      end
      nxt_ready = nxt_fill != 6'(`ACPS_FIFO_DEPTH);
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         fill_ff  <= '0;
         ready_ff <= 1'b1;
      end else if (clk_en) begin
         fill_ff  <= nxt_fill;
         ready_ff <= nxt_ready;
      end
   end

   acps_fifo #(
      .WIDTH (`ACPS_FIFO_WIDTH),
      .DEPTH (`ACPS_FIFO_DEPTH)
   ) u_fifo (
      .core_clk  (core_clk),
      .reset     (reset),
      .clk_en    (clk_en),
      .in_valid  (fifo_push),
      .in_ready  (),
      .in_data   (sample_in),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_data)
   );

   acps_state_e state_ff, nxt_state;
   logic [4:0]  edges_ff, nxt_edges;
   logic [15:0] shift_ff, nxt_shift;
   logic        sdo_ff, nxt_sdo;
   logic        oe_ff, nxt_oe;

   always_comb begin
      nxt_state = state_ff;
      nxt_edges = edges_ff;
      nxt_shift = shift_ff;
      nxt_sdo   = sdo_ff;
      nxt_oe    = oe_ff;
      nxt_res   = strap_ok_ff ? res_ff : res_sel;
      fifo_pop  = 1'b0;
      case (state_ff)
         ACPS_POWER_DOWN: begin
            if (cs_fall) begin
               // Empty FIFO gives zero code rather than stall the host
               nxt_state = ACPS_TRACK;
               nxt_edges = '0;
               nxt_shift = frame_word(res_ff,
                  fifo_valid ? fifo_data.code : '0);
               fifo_pop  = fifo_valid;
               nxt_sdo   = 1'b0;
               nxt_oe    = 1'b1;
            end
         end
         ACPS_TRACK, ACPS_CONVERT: begin
            if (cs_rise) begin
               nxt_state = ACPS_POWER_DOWN;
               nxt_oe    = 1'b0;
               nxt_sdo   = 1'b0;
            end else if (ck_fall) begin
               nxt_edges = edges_ff + 5'h01;
               nxt_shift = {shift_ff[14:0], 1'b0};
               nxt_sdo   = shift_ff[14];
               if (nxt_edges == `ACPS_HOLD_EDGE) begin
                  nxt_state = ACPS_CONVERT;
               end
               if (nxt_edges == last_edge(res_ff)) begin
                  nxt_state = ACPS_POWER_DOWN;
                  nxt_oe    = 1'b0;
                  nxt_sdo   = 1'b0;
               end
            end
         end
         default: begin
            nxt_state = ACPS_POWER_DOWN;
            nxt_oe    = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state_ff    <= ACPS_POWER_DOWN;
         edges_ff    <= '0;
         shift_ff    <= '0;
         sdo_ff      <= 1'b0;
         oe_ff       <= 1'b0;
         res_ff      <= ACPS_RES_12;
         strap_ok_ff <= 1'b0;
      end else if (clk_en) begin
         state_ff    <= nxt_state;
         edges_ff    <= nxt_edges;
         shift_ff    <= nxt_shift;
         sdo_ff      <= nxt_sdo;
         oe_ff       <= nxt_oe;
         res_ff      <= nxt_res;
         strap_ok_ff <= 1'b1;
      end
   end

   // Status flops mirror the next state so they align with pins
   acps_status_s status_ff, nxt_status;
   always_comb begin
      nxt_status.track   = nxt_state == ACPS_TRACK;
      nxt_status.powered = nxt_state != ACPS_POWER_DOWN;
      nxt_status.busy    = nxt_state == ACPS_CONVERT;
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         status_ff <= '0;
      end else if (clk_en) begin
         status_ff <= nxt_status;
      end
   end

   always_comb begin
      serial_result_out = sdo_ff;
      sample_ready      = ready_ff;
      serial_result_oe  = oe_ff;
      status            = status_ff;
   end
endmodule

// ===== testbench/acps_host_model.sv
// Host serial master model: drives select and link clock.
// Assumes 40 MHz core_clk; link clock 200 ns, idle high.
module acps_host_model (
   input  wire logic core_clk,
   input  wire logic result_line,
   output logic      conv_sel_n,
   output logic      serial_clk
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      conv_sel_n = 1'b1;
      serial_clk = 1'b1;
   end
   task automatic half();
      repeat (4) @(posedge core_clk);
   endtask
   // Reads one bit before each fall; stop below n aborts
   task automatic frame(input int stop, output logic [15:0] w);
      w = 16'h0;
      conv_sel_n <= 1'b0;
      half();
      half();
      for (int k = 1; k <= stop; k++) begin
         w = {w[14:0], result_line};
         serial_clk <= 1'b0;
         half();
         serial_clk <= 1'b1;
         half();
      end
      conv_sel_n <= 1'b1;
      repeat (12) @(posedge core_clk);
   endtask
endmodule

// ===== testbench/acps_properties.sv
// Checker on the sequencer's host pins and status.
// Assumes a bind to acps_top; pins sampled as raw inputs.
module acps_properties
   import acps_pkg::*;
(
   input wire logic         core_clk,
   input wire logic         reset,
   input wire logic [1:0]   res_sel,
   input wire logic         conv_sel_n,
   input wire logic         serial_clk,
   input wire logic         serial_result_out,
   input wire logic         serial_result_oe,
   input wire acps_status_s status
);
   logic       clk_q_ff;
   logic [4:0] cnt_ff;
   logic [4:0] n_last;
   logic       fall;
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   always_comb n_last = (res_sel == 2'h1) ? 5'h0E :
                        (res_sel == 2'h2) ? 5'h0C : 5'h10;
   always_comb fall = clk_q_ff && !serial_clk && !conv_sel_n;
   // Falls counted only inside a frame
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         clk_q_ff <= 1'b1;
         cnt_ff   <= 5'h00;
      end else begin
         clk_q_ff <= serial_clk;
         if (conv_sel_n) cnt_ff <= 5'h00;
         else if (fall) cnt_ff <= cnt_ff + 5'h01;
      end
   end
   wake_up_a: assert property ($fell(conv_sel_n) |-> ##[1:5]
      (serial_result_oe && status.track && status.powered
       && !serial_result_out)) else $error("no wake on select");
   track_kept_a: assert property (fall && cnt_ff == 5'h01 |->
      ##1 status.track [*5]) else $error("track left early");
   hold_edge_a: assert property (fall && cnt_ff == 5'h02 |->
      ##[1:5] (status.busy && !status.track)) else $error("no hold");
   early_end_a: assert property (fall && cnt_ff == n_last - 5'h02
      |-> ##1 serial_result_oe [*5]) else $error("frame ended early");
   power_down_a: assert property (fall && cnt_ff == n_last - 5'h01
      |-> ##[1:5] (!serial_result_oe && status == 3'h0))
      else $error("no power-down on last fall");
   abort_a: assert property ($rose(conv_sel_n) |-> ##[1:5]
      (!serial_result_oe && status == 3'h0)) else $error("no abort");
   idle_release_a: assert property (conv_sel_n [*5] |->
      !serial_result_oe) else $error("driving while deselected");
   hold_down_a: assert property (!status.powered |->
      (!status.track && !status.busy)) else $error("track in power-down");
   out_idle_a: assert property (!serial_result_oe |->
      !serial_result_out) else $error("data while released");
endmodule

// ===== testbench/tb_acps_top.sv
// Self-checking bench for the conversion and power sequencer.
// Assumes host model and checker compiled before this file.
module tb_acps_top;
   import acps_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic         core_clk     = 1'b0;
   logic         reset        = 1'b1;
   logic         sample_valid = 1'b0;
   logic         clk_en       = 1'b1;
   logic [1:0]   res_sel      = 2'h0;
   acps_sample_s sample_in    = '0;
   logic         sample_ready;
   logic         serial_result_out;
   logic         serial_result_oe;
   acps_status_s status;
   wire logic    conv_sel_n;
   wire logic    serial_clk;
   wire logic    result_line;
   int           failures = 0;
   int           n_tests  = 0;
   logic [15:0]  w;
   logic [1:0]   rs [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
   int           nf [4] = '{16, 14, 12, 16};
   logic [11:0]  cd [4] = '{12'hA5C, 12'hA5C, 12'hA5C, 12'hFFF};
   logic [15:0]  ex [4] = '{16'h0A5C, 16'h025C, 16'h005C, 16'h0FFF};
   always #12.5 core_clk = ~core_clk;
   assign result_line = serial_result_oe ? serial_result_out : 1'bz;
   acps_top acps_top_i (.core_clk(core_clk), .reset(reset),
      .clk_en(clk_en), .res_sel(res_sel), .sample_valid(sample_valid),
      .sample_ready(sample_ready), .sample_in(sample_in),
      .conv_sel_n(conv_sel_n), .serial_clk(serial_clk),
      .serial_result_out(serial_result_out),
      .serial_result_oe(serial_result_oe), .status(status));
   acps_host_model acps_host_model_i (.core_clk(core_clk),
      .result_line(result_line), .conv_sel_n(conv_sel_n),
      .serial_clk(serial_clk));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t saw %h, want %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic do_reset(input logic [1:0] r);
      reset   <= 1'b1;
      res_sel <= r;
      repeat (10) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      acps_host_model_i.frame(16, w);
   endtask
   task automatic push(input logic [11:0] c);
      sample_valid   <= 1'b1;
      sample_in.code <= c;
      @(posedge core_clk);
      sample_valid <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic idle_check();
      check(16'(serial_result_oe), 16'h0);
      check(16'(status), 16'h0);
      check(16'(sample_ready), 16'h1);
   endtask
   initial begin
      #400us;
      failures++;
      finish_test();
   end
   initial begin
      for (int i = 0; i < 4; i++) begin
         do_reset(rs[i]);
         push(cd[i]);
         acps_host_model_i.frame(nf[i], w);
         check(w, ex[i]);
         idle_check();
         $display("Variant row %0d done", i);
      end
      push(12'h800);
      acps_host_model_i.frame(5, w);
      check(w, 16'h0001);
      idle_check();
      $display("Abort test done");
      sample_valid <= 1'b1;
      for (int i = 0; i < 32; i++) begin
         sample_in.code <= 12'(i) + 12'h300;
         @(posedge core_clk);
      end
      #1 check(16'(sample_ready), 16'h0);
      repeat (3) @(posedge core_clk);
      sample_valid <= 1'b0;
      for (int i = 0; i < 32; i++) begin
         acps_host_model_i.frame(16, w);
         check(w, 16'(i) + 16'h0300);
      end
      acps_host_model_i.frame(16, w);
      check(w, 16'h0000);
      $display("Buffer test done");
      // Frozen enable must drop the offered sample
      clk_en         <= 1'b0;
      sample_valid   <= 1'b1;
      sample_in.code <= 12'h123;
      repeat (3) @(posedge core_clk);
      clk_en       <= 1'b1;
      sample_valid <= 1'b0;
      @(posedge core_clk);
      acps_host_model_i.frame(16, w);
      check(w, 16'h0000);
      $display("Enable test done");
      finish_test();
   end
endmodule
bind acps_top acps_properties acps_properties_i (.core_clk(core_clk),
   .reset(reset), .res_sel(res_sel), .conv_sel_n(conv_sel_n),
   .serial_clk(serial_clk), .serial_result_out(serial_result_out),
   .serial_result_oe(serial_result_oe), .status(status));
